/* File: inc/spi_stat_pkg.sv */
package spi_stat_pkg;
  // ==========================================================================
  // Register map.
  localparam logic [7:0]  ADDR_STAT      = 8'h00;
  localparam logic [7:0]  ADDR_DATA      = 8'h04;
  localparam logic [7:0]  ADDR_CFG       = 8'h08;
  // ==========================================================================
  // Status and control fields.
  localparam int          BIT_ON         = 15;
  localparam int          BIT_HALT       = 13;
  localparam int          BIT_ROV        = 6;
  localparam int          BIT_TBF        = 1;
  localparam int          BIT_RBF        = 0;
  localparam logic [15:0] STAT_RESET     = 16'h0000;
  localparam logic [15:0] STAT_WMASK     = 16'hA000;
  // ==========================================================================
  // Configuration fields.
  localparam int          BIT_IDLE       = 0;
  // ==========================================================================
  // Bus answers and frame size.
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;
  localparam logic [3:0]  LAST_BIT       = 4'h7;
  localparam logic [3:0]  CNT_RESET      = 4'h0;
endpackage

/* File: design/spi_stat.sv */
`timescale 1ns/1ps
// Contract
// - Enable bit 15 makes the port active and gives it the serial pins.
// - Halt-in-idle bit 13 stops the port while the device idles.
// - A reception while receive buffer full sets overflow bit 6; data dropped.
// - CPU write of data window loads transmit buffer and sets bit 1.
// - Move of transmit buffer into shift register clears bit 1.
// - Completed reception moved into receive buffer sets bit 0.
// - CPU read of data window empties receive buffer and clears bit 0.
// - Unimplemented status bits 14, 12..7 and 5..2 read as zero.
module spi_stat (
  input  wire logic        clock,          // System clock, 40 MHz.
  input  wire logic        rstn,           // Asynchronous reset, active low.
  input  wire logic [7:0]  s_axi_awaddr,   // Write address.
  input  wire logic        s_axi_awvalid,  // Write address valid.
  output logic             s_axi_awready,  // Write address ready.
  input  wire logic [31:0] s_axi_wdata,    // Write data.
  input  wire logic [3:0]  s_axi_wstrb,    // Write strobes.
  input  wire logic        s_axi_wvalid,   // Write data valid.
  output logic             s_axi_wready,   // Write data ready.
  output logic [1:0]       s_axi_bresp,    // Write response.
  output logic             s_axi_bvalid,   // Write response valid.
  input  wire logic        s_axi_bready,   // Write response ready.
  input  wire logic [7:0]  s_axi_araddr,   // Read address.
  input  wire logic        s_axi_arvalid,  // Read address valid.
  output logic             s_axi_arready,  // Read address ready.
  output logic [31:0]      s_axi_rdata,    // Read data.
  output logic [1:0]       s_axi_rresp,    // Read response.
  output logic             s_axi_rvalid,   // Read data valid.
  input  wire logic        s_axi_rready,   // Read data ready.
  input  wire logic        serial_clock_pin, // Link clock from the master.
  input  wire logic        slave_select_pin, // Frame select, active low.
  input  wire logic        serial_in_pin,  // Serial data in.
  output logic             serial_out_pin, // Serial data out.
  output logic             serial_out_oen, // Output enable, low drives.
  output logic             port_pins_owned // Pins belong to the port.
);
  // ==========================================================================
  // Core-domain state.
  logic [15:0] stat_r, stat_nxt;
  logic        idle_r, idle_nxt;
  logic [7:0]  txb_r, txb_nxt, rxb_r, rxb_nxt;
  logic        aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [7:0]  awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [3:0]  ws_r, ws_nxt;
  logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
  logic        own_r, own_nxt;
  // Crossing state: toggles for events, a snapshot word held stable.
  logic        ld_tgl_r, ld_tgl_nxt;      // Core: transmit buffer offered.
  logic [2:0]  tk_sync_r, dn_sync_r;      // Core: synchronisers from link.
  logic        tk_tgl_r, dn_tgl_r, ld_seen_r;
  logic [7:0]  sh_r, rxw_r;
  logic [3:0]  cnt_r;
  logic        active, frame_rst_n;
  logic        wr_go, rd_go, tk_ev, dn_ev;

  assign active = stat_r[spi_stat_pkg::BIT_ON] &
                  ~(stat_r[spi_stat_pkg::BIT_HALT] & idle_r);
  assign tk_ev = tk_sync_r[2] ^ tk_sync_r[1];
  assign dn_ev = dn_sync_r[2] ^ dn_sync_r[1];
  assign wr_go = aw_r & w_r & ~bv_r;
  assign rd_go = s_axi_arvalid & ~rv_r;
  assign frame_rst_n = rstn & ~slave_select_pin;

  // ==========================================================================
  // Bus slave and status register.
  always_comb begin
    aw_nxt = aw_r;
    w_nxt = w_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    ws_nxt = ws_r;
    bv_nxt = bv_r;
    br_nxt = br_r;
    rv_nxt = rv_r;
    rr_nxt = rr_r;
    rd_nxt = rd_r;
    stat_nxt = stat_r;
    idle_nxt = idle_r;
    txb_nxt = txb_r;
    rxb_nxt = rxb_r;
    ld_tgl_nxt = ld_tgl_r;
    own_nxt = stat_r[spi_stat_pkg::BIT_ON];
    if (s_axi_awvalid && !aw_r && !bv_r) begin
      aw_nxt = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_r && !bv_r) begin
      w_nxt = 1'b1;
      wd_nxt = s_axi_wdata;
      ws_nxt = s_axi_wstrb;
    end
    if (bv_r && s_axi_bready) begin
      bv_nxt = 1'b0;
    end
    if (rv_r && s_axi_rready) begin
      rv_nxt = 1'b0;
    end
    // Transmit holding buffer taken into the shift register.
    if (tk_ev) begin
      stat_nxt[spi_stat_pkg::BIT_TBF] = 1'b0;
    end
    // Completed reception: keep it only if the buffer is empty.
    if (dn_ev) begin
      if (stat_r[spi_stat_pkg::BIT_RBF]) begin
        stat_nxt[spi_stat_pkg::BIT_ROV] = 1'b1;
      end else begin
        rxb_nxt = rxw_r;
        stat_nxt[spi_stat_pkg::BIT_RBF] = 1'b1;
      end
    end
    if (wr_go) begin
      aw_nxt = 1'b0;
      w_nxt = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = spi_stat_pkg::RESP_OKAY;
      case (awa_r)
        spi_stat_pkg::ADDR_STAT: begin
          if (ws_r[1]) begin
            stat_nxt[15:8] = (stat_nxt[15:8] & ~spi_stat_pkg::STAT_WMASK[15:8]) |
                             (wd_r[15:8] & spi_stat_pkg::STAT_WMASK[15:8]);
          end
          // Clear wins only when no reception completes in the same cycle.
          if (ws_r[0] && !wd_r[spi_stat_pkg::BIT_ROV] && !dn_ev) begin
            stat_nxt[spi_stat_pkg::BIT_ROV] = 1'b0;
          end
        end
        spi_stat_pkg::ADDR_DATA: begin
          if (ws_r[0]) begin
            txb_nxt = wd_r[7:0];
            stat_nxt[spi_stat_pkg::BIT_TBF] = 1'b1;
            ld_tgl_nxt = ~ld_tgl_r;
          end
        end
        spi_stat_pkg::ADDR_CFG: begin
          if (ws_r[0]) begin
            idle_nxt = wd_r[spi_stat_pkg::BIT_IDLE];
          end
        end
        default: br_nxt = spi_stat_pkg::RESP_SLVERR;
      endcase
    end
    if (rd_go) begin
      rv_nxt = 1'b1;
      rr_nxt = spi_stat_pkg::RESP_OKAY;
      rd_nxt = '0;
      case (s_axi_araddr)
        spi_stat_pkg::ADDR_STAT: rd_nxt[15:0] = stat_r;
        spi_stat_pkg::ADDR_DATA: begin
          rd_nxt[7:0] = rxb_r;
          if (!(dn_ev && !stat_r[spi_stat_pkg::BIT_RBF])) begin
            stat_nxt[spi_stat_pkg::BIT_RBF] = 1'b0;
          end
        end
        spi_stat_pkg::ADDR_CFG: rd_nxt[spi_stat_pkg::BIT_IDLE] = idle_r;
        default: rr_nxt = spi_stat_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stat_r <= spi_stat_pkg::STAT_RESET;
      idle_r <= 1'b0;
      txb_r <= '0;
      rxb_r <= '0;
      aw_r <= 1'b0;
      w_r <= 1'b0;
      bv_r <= 1'b0;
      rv_r <= 1'b0;
      awa_r <= '0;
      wd_r <= '0;
      ws_r <= '0;
      rd_r <= '0;
      br_r <= spi_stat_pkg::RESP_OKAY;
      rr_r <= spi_stat_pkg::RESP_OKAY;
      ld_tgl_r <= 1'b0;
      own_r <= 1'b0;
      tk_sync_r <= '0;
      dn_sync_r <= '0;
    end else begin
      stat_r <= stat_nxt;
      idle_r <= idle_nxt;
      txb_r <= txb_nxt;
      rxb_r <= rxb_nxt;
      aw_r <= aw_nxt;
      w_r <= w_nxt;
      bv_r <= bv_nxt;
      rv_r <= rv_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      ws_r <= ws_nxt;
      rd_r <= rd_nxt;
      br_r <= br_nxt;
      rr_r <= rr_nxt;
      ld_tgl_r <= ld_tgl_nxt;
      own_r <= own_nxt;
      tk_sync_r <= {tk_sync_r[1:0], tk_tgl_r};
      dn_sync_r <= {dn_sync_r[1:0], dn_tgl_r};
    end
  end

  assign s_axi_awready = aw_r;
  assign s_axi_wready = w_r;
  assign s_axi_bvalid = bv_r;
  assign s_axi_bresp = br_r;
  assign s_axi_arready = rv_r;
  assign s_axi_rvalid = rv_r;
  assign s_axi_rdata = rd_r;
  assign s_axi_rresp = rr_r;
  assign port_pins_owned = own_r;

  // ==========================================================================
  // Link domain: slave-mode shifter on the serial clock, MSB first.
  // The link clock runs only inside frames, so nothing could be synchronised on it.
  // Enable, load toggle and transmit buffer are read as static: change them between frames.
  logic [7:0] sh_nxt, rxw_nxt;
  logic [3:0] cnt_nxt;
  logic       tk_nxt, dn_nxt, seen_nxt, sel;
  always_comb begin
    sel = active & ~slave_select_pin;
    sh_nxt = sh_r;
    rxw_nxt = rxw_r;
    cnt_nxt = cnt_r;
    tk_nxt = tk_tgl_r;
    dn_nxt = dn_tgl_r;
    seen_nxt = ld_seen_r;
    if (!sel) begin
      cnt_nxt = spi_stat_pkg::CNT_RESET;
    end else begin
      if (cnt_r == spi_stat_pkg::CNT_RESET && ld_tgl_r != ld_seen_r) begin
        sh_nxt = txb_r;
        seen_nxt = ld_tgl_r;
        tk_nxt = ~tk_tgl_r;
      end
      sh_nxt = {sh_nxt[6:0], serial_in_pin};
      if (cnt_r == spi_stat_pkg::LAST_BIT) begin
        cnt_nxt = spi_stat_pkg::CNT_RESET;
        rxw_nxt = {sh_r[6:0], serial_in_pin};
        dn_nxt = ~dn_tgl_r;
      end else begin
        cnt_nxt = cnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge serial_clock_pin or negedge rstn) begin
    if (!rstn) begin
      sh_r <= '0;
      rxw_r <= '0;
      tk_tgl_r <= 1'b0;
      dn_tgl_r <= 1'b0;
      ld_seen_r <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      rxw_r <= rxw_nxt;
      tk_tgl_r <= tk_nxt;
      dn_tgl_r <= dn_nxt;
      ld_seen_r <= seen_nxt;
    end
  end

  always_ff @(posedge serial_clock_pin or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt_r <= spi_stat_pkg::CNT_RESET;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Data changes on the falling edge so the master samples a settled bit.
  always_ff @(negedge serial_clock_pin or negedge rstn) begin
    if (!rstn) begin
      serial_out_pin <= 1'b0;
    end else begin
      serial_out_pin <= sh_r[7];
    end
  end
  // Deselect releases the pin at once; driving starts at the first falling edge.
  always_ff @(negedge serial_clock_pin or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      serial_out_oen <= 1'b1;
    end else begin
      serial_out_oen <= ~sel;
    end
  end

  // ==========================================================================
  // Checks.
  property p_unused_zero;
    @(posedge clock) disable iff (!rstn)
      (stat_r & 16'h5FBC) == 16'h0000;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");
  property p_tbf_set;
    @(posedge clock) disable iff (!rstn)
      wr_go && awa_r == spi_stat_pkg::ADDR_DATA && ws_r[0] |=> stat_r[1];
  endproperty
  a_tbf_set: assert property (p_tbf_set) else $error("tx full not set");
  property p_tbf_clr;
    @(posedge clock) disable iff (!rstn)
      tk_ev && !(wr_go && awa_r == spi_stat_pkg::ADDR_DATA) |=> !stat_r[1];
  endproperty
  a_tbf_clr: assert property (p_tbf_clr) else $error("tx full not cleared");
  property p_rbf_set;
    @(posedge clock) disable iff (!rstn)
      dn_ev && !stat_r[0] |=> stat_r[0] && rxb_r == $past(rxw_r);
  endproperty
  a_rbf_set: assert property (p_rbf_set) else $error("rx full not set");
  property p_rov_set;
    @(posedge clock) disable iff (!rstn)
      dn_ev && stat_r[0] |=> stat_r[6] && $stable(rxb_r);
  endproperty
  a_rov_set: assert property (p_rov_set) else $error("overflow missed");
  property p_rbf_clr;
    @(posedge clock) disable iff (!rstn)
      rd_go && s_axi_araddr == spi_stat_pkg::ADDR_DATA && !dn_ev |=> !stat_r[0];
  endproperty
  a_rbf_clr: assert property (p_rbf_clr) else $error("rx full not cleared");
  property p_rov_hold;
    @(posedge clock) disable iff (!rstn)
      stat_r[6] && !(wr_go && awa_r == spi_stat_pkg::ADDR_STAT) |=> stat_r[6];
  endproperty
  a_rov_hold: assert property (p_rov_hold) else $error("overflow lost");
  property p_own;
    @(posedge clock) disable iff (!rstn)
      $rose(stat_r[15]) |=> port_pins_owned;
  endproperty
  a_own: assert property (p_own) else $error("pins not owned");
  property p_halt;
    @(posedge clock) disable iff (!rstn)
      stat_r[13] && idle_r |-> !active;
  endproperty
  a_halt: assert property (p_halt) else $error("port runs in idle");
endmodule

/* File: verif/link_master.sv */
`timescale 1ns/1ps
// ============================================================================
// Master side of the link. Its clock rests low between frames, as a real
// master's would, so the port never sees edges outside a frame.
module link_master (
  output logic sclk,  // Link clock, 48 ns period.
  output logic ss_n,  // Select, active low.
  output logic mosi,  // Data towards the port.
  input  logic miso   // Data from the port.
);
  logic [7:0] got;

  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
    got = 8'h00;
  end

  task automatic frame(input logic [7:0] tx);
    ss_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #12 sclk = 1'b1;
      got = {got[6:0], miso};
      #24 sclk = 1'b0;
      #12;
    end
    ss_n = 1'b1;
    // A released line shows the inverse, so that a stale bit cannot pass.
    mosi = ~mosi;
    // The select stays high for a while so that back-to-back frames stay apart.
    #24;
  endtask
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        clock, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, sclk, ss_n, mosi;
  logic        miso, miso_oen, owned, miso_line;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] d;
  int          errors, n_compared;

  spi_stat uut (
    .clock(clock), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_clock_pin(sclk), .slave_select_pin(ss_n), .serial_in_pin(mosi),
    .serial_out_pin(miso), .serial_out_oen(miso_oen), .port_pins_owned(owned)
  );
  link_master m (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso_line));

  // A released line shows the inverse of the last bit, so stale data cannot pass.
  assign miso_line = miso_oen ? ~miso : miso;

  always #12.5 clock = ~clock;

  // ==========================================================================
  // Checking and closing.
  task automatic wrap_up();
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hung();
    errors++;
    wrap_up();
  endtask

  // ==========================================================================
  // Bus master tasks; every wait is bounded.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 50);
    r = bresp;
    bready <= 1'b0;
    if (n >= 50) hung();
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 50) hung();
  endtask

  task automatic wchk(input logic [7:0] a, input logic [31:0] v);
    wr(a, v);
    chk({30'h0, r}, {30'h0, spi_stat_pkg::RESP_OKAY});
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, spi_stat_pkg::RESP_OKAY});
  endtask

  task automatic settle();
    repeat (8) @(posedge clock);
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    errors = 0;
    n_compared = 0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    chk({31'h0, owned}, 32'h0000_0000);
    rchk(spi_stat_pkg::ADDR_STAT, 32'h0000_0000);
    wchk(spi_stat_pkg::ADDR_STAT, 32'h0000_FFFF);
    rchk(spi_stat_pkg::ADDR_STAT, 32'h0000_A000);
    chk({31'h0, owned}, 32'h0000_0001);
    wchk(spi_stat_pkg::ADDR_STAT, 32'h0000_8000);
    wchk(spi_stat_pkg::ADDR_DATA, 32'h0000_00A5);
    rchk(spi_stat_pkg::ADDR_STAT, 32'h0000_8002);
    fork
      m.frame(8'h3C);
      begin
        #200;
        chk({31'h0, miso_oen}, 32'h0000_0000);
      end
    join
    settle();
    rchk(spi_stat_pkg::ADDR_STAT, 32'h0000_8001);
    rchk(spi_stat_pkg::ADDR_DATA, 32'h0000_003C);
    rchk(spi_stat_pkg::ADDR_STAT, 32'h0000_8000);
    // The leading bit slot is not driven yet, so only the seven bits after it are compared.
    m.frame(8'h11);
    chk({25'h0, m.got[6:0]}, 32'h0000_003C);
    m.frame(8'h22);
    chk({25'h0, m.got[6:0]}, 32'h0000_0011);
    settle();
    rchk(spi_stat_pkg::ADDR_STAT, 32'h0000_8041);
    rchk(spi_stat_pkg::ADDR_DATA, 32'h0000_0011);
    wstrb <= 4'h2;
    wchk(spi_stat_pkg::ADDR_STAT, 32'h0000_8000);
    wstrb <= 4'hF;
    rchk(spi_stat_pkg::ADDR_STAT, 32'h0000_8040);
    wchk(spi_stat_pkg::ADDR_STAT, 32'h0000_8040);
    rchk(spi_stat_pkg::ADDR_STAT, 32'h0000_8040);
    wchk(spi_stat_pkg::ADDR_STAT, 32'h0000_8000);
    rchk(spi_stat_pkg::ADDR_STAT, 32'h0000_8000);
    wchk(spi_stat_pkg::ADDR_CFG, 32'h0000_0001);
    wchk(spi_stat_pkg::ADDR_STAT, 32'h0000_A000);
    m.frame(8'h55);
    settle();
    rchk(spi_stat_pkg::ADDR_STAT, 32'h0000_A000);
    wchk(spi_stat_pkg::ADDR_CFG, 32'h0000_0000);
    wchk(spi_stat_pkg::ADDR_STAT, 32'h0000_0000);
    fork
      m.frame(8'h66);
      begin
        #200;
        chk({31'h0, miso_oen}, 32'h0000_0001);
      end
    join
    settle();
    rchk(spi_stat_pkg::ADDR_STAT, 32'h0000_0000);
    chk({31'h0, owned}, 32'h0000_0000);
    wr(8'h0C, 32'h0000_FFFF);
    chk({30'h0, r}, {30'h0, spi_stat_pkg::RESP_SLVERR});
    rd(8'h0C);
    chk({30'h0, r}, {30'h0, spi_stat_pkg::RESP_SLVERR});
    rchk(spi_stat_pkg::ADDR_STAT, 32'h0000_0000);
    wrap_up();
  end
endmodule
